/* File: core/spcg_consts.vh */
// Purpose: Constants for the sleep peripheral clock gating block
// Assumes: 32-bit register port, byte addresses
// Notes: Offsets are byte addresses
`ifndef SPCG_CONSTS_VH
`define SPCG_CONSTS_VH
`define SPCG_OFF_RUN_GATE 12'h104
`define SPCG_OFF_SLEEP_GATE 12'h114
`define SPCG_OFF_DEEP_GATE 12'h124
`define SPCG_OFF_RUN_CLK_CFG 12'h060
`define SPCG_OFF_INT_STATUS 12'h200
`define SPCG_OFF_INT_MASK 12'h204
`define SPCG_OFF_POWER_STATE 12'h208
`define SPCG_GATE_RESET 32'h00000000
`define SPCG_GATE_MASK 32'h07071013
`define SPCG_AUTO_GATE_BIT 22
`define SPCG_BIT_ASYNC_A 0
`define SPCG_BIT_ASYNC_B 1
`define SPCG_BIT_SYNC_SER 4
`define SPCG_BIT_TWO_WIRE 12
`define SPCG_BIT_TIMER_A 16
`define SPCG_BIT_TIMER_B 17
`define SPCG_BIT_TIMER_C 18
`define SPCG_BIT_COMP_A 24
`define SPCG_BIT_COMP_B 25
`define SPCG_BIT_COMP_C 26
`define SPCG_PERIPH_COUNT 10
`define SPCG_PERIPH_SLOTS 4
`define SPCG_INT_FAULT_BIT 0
`define SPCG_INT_STATE_BIT 1
`define SPCG_INT_MASK_BITS 32'h00000003
`define SPCG_PS_RUN 2'h0
`define SPCG_PS_SLEEP 2'h1
`define SPCG_PS_DEEP 2'h2
`endif

/* File: core/spcg_sleep_gate_ctrl.v */
// Purpose: Run, sleep and deep-sleep peripheral clock gate registers and enable selection
// Assumes: Single clock; power state and peripheral access requests come from the same clock
// Notes: Gate enables and fault outputs are registered
`timescale 1ns/1ps
`include "spcg_consts.vh"

module spcg_sleep_gate_ctrl #(
	parameter ADDR_W = 12
) (
	input wire clk,
	input wire rst_b,
	input wire [ADDR_W-1:0] regAddr,
	input wire [31:0] regWdata,
	input wire regWrite,
	input wire regRead,
	output reg [31:0] regRdata,
	input wire [1:0] powerState,
	input wire [31:0] periphAccess,
	output reg [31:0] periphClkEn,
	output reg busFault,
	output reg [31:0] faultTarget,
	output reg irq
);
	// Stored gate and control registers
	reg [31:0] runGate_r;
	reg [31:0] sleepGate_r;
	reg [31:0] deepGate_r;
	reg [31:0] runClkCfg_r;
	reg [1:0] intStatus_r;
	reg [1:0] intMask_r;
	reg [1:0] prevState_r;

	// Next values, all combinational
	reg [31:0] runGate_nxt;
	reg [31:0] sleepGate_nxt;
	reg [31:0] deepGate_nxt;
	reg [31:0] runClkCfg_nxt;
	reg [1:0] intStatus_nxt;
	reg [1:0] intMask_nxt;
	reg [31:0] activeGate_nxt;
	reg [31:0] rdata_nxt;
	reg irq_nxt;

	// Address decodes and write enables
	wire selRunGate;
	wire selSleepGate;
	wire selDeepGate;
	wire selRunClkCfg;
	wire selIntStatus;
	wire selIntMask;
	wire selPowerState;
	wire wrRunGate;
	wire wrSleepGate;
	wire wrDeepGate;
	wire wrRunClkCfg;
	wire wrIntStatus;
	wire wrIntMask;

	wire [31:0] faultHits;
	wire autoGate;
	wire stateChange;
	wire faultEvt;

	// Writable gate bits only; every reserved bit comes back as zero
	function [31:0] gateMask;
		input [31:0] value;
		begin
			gateMask = 32'h00000000;
			gateMask[`SPCG_BIT_ASYNC_A] = value[`SPCG_BIT_ASYNC_A];
			gateMask[`SPCG_BIT_ASYNC_B] = value[`SPCG_BIT_ASYNC_B];
			gateMask[`SPCG_BIT_SYNC_SER] = value[`SPCG_BIT_SYNC_SER];
			gateMask[`SPCG_BIT_TWO_WIRE] = value[`SPCG_BIT_TWO_WIRE];
			gateMask[`SPCG_BIT_TIMER_A] = value[`SPCG_BIT_TIMER_A];
			gateMask[`SPCG_BIT_TIMER_B] = value[`SPCG_BIT_TIMER_B];
			gateMask[`SPCG_BIT_TIMER_C] = value[`SPCG_BIT_TIMER_C];
			gateMask[`SPCG_BIT_COMP_A] = value[`SPCG_BIT_COMP_A];
			gateMask[`SPCG_BIT_COMP_B] = value[`SPCG_BIT_COMP_B];
			gateMask[`SPCG_BIT_COMP_C] = value[`SPCG_BIT_COMP_C];
		end
	endfunction

	// Exact match on the full address, so no register has an alias
	function hitReg;
		input [ADDR_W-1:0] addr;
		input [11:0] off;
		begin
			hitReg = (addr == off[ADDR_W-1:0]);
		end
	endfunction

	assign selRunGate = hitReg(regAddr, `SPCG_OFF_RUN_GATE);
	assign selSleepGate = hitReg(regAddr, `SPCG_OFF_SLEEP_GATE);
	assign selDeepGate = hitReg(regAddr, `SPCG_OFF_DEEP_GATE);
	assign selRunClkCfg = hitReg(regAddr, `SPCG_OFF_RUN_CLK_CFG);
	assign selIntStatus = hitReg(regAddr, `SPCG_OFF_INT_STATUS);
	assign selIntMask = hitReg(regAddr, `SPCG_OFF_INT_MASK);
	assign selPowerState = hitReg(regAddr, `SPCG_OFF_POWER_STATE);
	// Writes land in every cycle the strobe is high beside a matching address
	assign wrRunGate = regWrite & selRunGate;
	assign wrSleepGate = regWrite & selSleepGate;
	assign wrDeepGate = regWrite & selDeepGate;
	assign wrRunClkCfg = regWrite & selRunClkCfg;
	assign wrIntStatus = regWrite & selIntStatus;
	assign wrIntMask = regWrite & selIntMask;

	assign autoGate = runClkCfg_r[`SPCG_AUTO_GATE_BIT];
	// Checked against the enables currently driven to the gates
	assign faultHits = gateMask(periphAccess & ~periphClkEn);
	assign faultEvt = |faultHits;
	assign stateChange = (prevState_r != powerState);

	// Without auto gating the run enables stay in force in both sleep states
	always @* begin
		case (powerState)
			`SPCG_PS_RUN: begin
				activeGate_nxt = runGate_r;
			end
			`SPCG_PS_SLEEP: begin
				activeGate_nxt = autoGate ? sleepGate_r : runGate_r;
			end
			`SPCG_PS_DEEP: begin
				activeGate_nxt = autoGate ? deepGate_r : runGate_r;
			end
			default: begin
				activeGate_nxt = runGate_r;
			end
		endcase
	end

	// Each gate register holds its value unless written
	always @* begin
		runGate_nxt = runGate_r;
		if (wrRunGate) begin
			runGate_nxt = gateMask(regWdata);
		end
	end

	always @* begin
		sleepGate_nxt = sleepGate_r;
		if (wrSleepGate) begin
			sleepGate_nxt = gateMask(regWdata);
		end
	end

	always @* begin
		deepGate_nxt = deepGate_r;
		if (wrDeepGate) begin
			deepGate_nxt = gateMask(regWdata);
		end
	end

	// The configuration word is kept whole; only the auto gating bit acts here
	always @* begin
		runClkCfg_nxt = runClkCfg_r;
		if (wrRunClkCfg) begin
			runClkCfg_nxt = regWdata;
		end
	end

	always @* begin
		intMask_nxt = intMask_r;
		if (wrIntMask) begin
			intMask_nxt = regWdata[1:0];
		end
	end

	// Write one to clear; a hardware set in the same cycle wins over the clear
	always @* begin
		intStatus_nxt = intStatus_r;
		if (wrIntStatus) begin
			intStatus_nxt = intStatus_r & ~regWdata[1:0];
		end
		if (faultEvt) begin
			intStatus_nxt[`SPCG_INT_FAULT_BIT] = 1'b1;
		end
		if (stateChange) begin
			intStatus_nxt[`SPCG_INT_STATE_BIT] = 1'b1;
		end
	end

	always @* begin
		irq_nxt = |(intStatus_r & intMask_r);
	end

	// Unmapped addresses read zero
	always @* begin
		rdata_nxt = 32'h00000000;
		if (selRunGate) begin
			rdata_nxt = runGate_r;
		end else if (selSleepGate) begin
			rdata_nxt = sleepGate_r;
		end else if (selDeepGate) begin
			rdata_nxt = deepGate_r;
		end else if (selRunClkCfg) begin
			rdata_nxt = runClkCfg_r;
		end else if (selIntStatus) begin
			rdata_nxt = {30'h00000000, intStatus_r};
		end else if (selIntMask) begin
			rdata_nxt = {30'h00000000, intMask_r};
		end else if (selPowerState) begin
			rdata_nxt = {30'h00000000, powerState};
		end
	end

	// All gated peripherals start unclocked until software enables them
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			runGate_r <= `SPCG_GATE_RESET;
		end else begin
			runGate_r <= runGate_nxt;
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			sleepGate_r <= `SPCG_GATE_RESET;
		end else begin
			sleepGate_r <= sleepGate_nxt;
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			deepGate_r <= `SPCG_GATE_RESET;
		end else begin
			deepGate_r <= deepGate_nxt;
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			runClkCfg_r <= 32'h00000000;
		end else begin
			runClkCfg_r <= runClkCfg_nxt;
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			intMask_r <= 2'h0;
		end else begin
			intMask_r <= intMask_nxt;
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			intStatus_r <= 2'h0;
		end else begin
			intStatus_r <= intStatus_nxt;
		end
	end

	// Read data stand for the one cycle after the strobe and are zero otherwise
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			regRdata <= 32'h00000000;
		end else if (regRead) begin
			regRdata <= rdata_nxt;
		end else begin
			regRdata <= 32'h00000000;
		end
	end

	// Registered enables keep glitches off the peripheral clock gates
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			periphClkEn <= `SPCG_GATE_RESET;
		end else begin
			periphClkEn <= activeGate_nxt;
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			busFault <= 1'b0;
			faultTarget <= 32'h00000000;
		end else begin
			busFault <= faultEvt;
			faultTarget <= faultHits;
		end
	end

	// Previous power state feeds the state change status bit
	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			prevState_r <= `SPCG_PS_RUN;
		end else begin
			prevState_r <= powerState;
		end
	end

	always @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			irq <= 1'b0;
		end else begin
			irq <= irq_nxt;
		end
	end
endmodule // spcg_sleep_gate_ctrl

/* File: verification/spcg_chk_sva.sv */
// Purpose: Port assertions for the sleep gate block
// Assumes: One clock, async low reset
// Notes: Shadows gate writes to predict the enables
`timescale 1ns/1ps
module spcg_chk (
	input wire clk,
	input wire rst_b,
	input wire [11:0] regAddr,
	input wire [31:0] regWdata,
	input wire regWrite,
	input wire regRead,
	input wire [31:0] regRdata,
	input wire [1:0] powerState,
	input wire [31:0] periphAccess,
	input wire [31:0] periphClkEn,
	input wire busFault,
	input wire [31:0] faultTarget,
	input wire irq
);
	default clocking @(posedge clk); endclocking
	default disable iff (!rst_b);
	localparam logic [31:0] M = 32'h07071013;
	logic [31:0] run_r, slp_r, dp_r;
	logic auto_r;
	always_ff @(posedge clk or negedge rst_b) begin
		if (!rst_b) begin
			run_r <= 32'h0;
			slp_r <= 32'h0;
			dp_r <= 32'h0;
			auto_r <= 1'b0;
		end else if (regWrite) begin
			if (regAddr == 12'h104) run_r <= regWdata & M;
			if (regAddr == 12'h114) slp_r <= regWdata & M;
			if (regAddr == 12'h124) dp_r <= regWdata & M;
			if (regAddr == 12'h060) auto_r <= regWdata[22];
		end
	end
	a_reset_zero: assert property (disable iff (1'b0)
		!rst_b |-> periphClkEn == 32'h0 && !busFault && !irq) else $error("not clear in reset");
	a_fault_flag: assert property (busFault == (faultTarget != 32'h0))
		else $error("fault flag wrong");
	a_fault_cause: assert property (
		faultTarget == ($past(periphAccess) & ~$past(periphClkEn) & M)) else $error("bad target");
	a_rsvd_en: assert property ((periphClkEn & ~M) == 32'h0)
		else $error("reserved enable set");
	a_read_back: assert property ($past(regRead) && $past(regAddr) == 12'h114
		|-> regRdata == $past(slp_r)) else $error("sleep gate readback");
	a_run_src: assert property ($past(powerState) != 2'h1 && $past(powerState) != 2'h2
		|-> periphClkEn == $past(run_r)) else $error("run source");
	a_sleep_auto: assert property ($past(powerState) == 2'h1 && $past(auto_r)
		|-> periphClkEn == $past(slp_r)) else $error("sleep source");
	a_sleep_run: assert property ($past(powerState) == 2'h1 && !$past(auto_r)
		|-> periphClkEn == $past(run_r)) else $error("sleep without auto");
	a_deep_src: assert property ($past(powerState) == 2'h2
		|-> periphClkEn == ($past(auto_r) ? $past(dp_r) : $past(run_r))) else $error("deep source");
endmodule // spcg_chk
bind spcg_sleep_gate_ctrl spcg_chk u_chk (.clk(clk), .rst_b(rst_b), .regAddr(regAddr),
	.regWdata(regWdata), .regWrite(regWrite), .regRead(regRead), .regRdata(regRdata),
	.powerState(powerState), .periphAccess(periphAccess), .periphClkEn(periphClkEn),
	.busFault(busFault), .faultTarget(faultTarget), .irq(irq));

/* File: verification/tb_top.sv */
// Purpose: Directed register and gating test
// Assumes: Read data one cycle after the strobe
// Notes: Power state and access lines driven directly
`timescale 1ns/1ps
module tb_top;
	logic clk = 0, rst_b = 1, regWrite = 0, regRead = 0;
	logic [11:0] regAddr = 0;
	logic [31:0] regWdata = 0, periphAccess = 0;
	logic [1:0] powerState = 0;
	wire [31:0] regRdata, periphClkEn, faultTarget;
	wire busFault, irq;
	int fails = 0, compares = 0;
	spcg_sleep_gate_ctrl uut (.clk(clk), .rst_b(rst_b), .regAddr(regAddr), .regWdata(regWdata),
		.regWrite(regWrite), .regRead(regRead), .regRdata(regRdata), .powerState(powerState),
		.periphAccess(periphAccess), .periphClkEn(periphClkEn), .busFault(busFault),
		.faultTarget(faultTarget), .irq(irq));
	initial forever #2 clk = ~clk;
	task chk(input logic [31:0] seen, input logic [31:0] exp);
		compares++;
		if (seen !== exp) begin
			fails++;
			$display("FAIL t=%0t seen=%h exp=%h", $time, seen, exp);
		end
	endtask
	task wr(input logic [11:0] a, input logic [31:0] d);
		@(posedge clk);
		regWrite <= 1'b1;
		regAddr <= a;
		regWdata <= d;
		@(posedge clk);
		regWrite <= 1'b0;
	endtask
	task rdc(input logic [11:0] a, input logic [31:0] exp);
		@(posedge clk);
		regRead <= 1'b1;
		regAddr <= a;
		@(posedge clk);
		regRead <= 1'b0;
		@(negedge clk);
		chk(regRdata, exp);
	endtask
	task ps(input logic [1:0] s);
		@(posedge clk);
		powerState <= s;
		repeat (3) @(negedge clk);
	endtask
	task fault(input logic [31:0] acc);
		@(posedge clk);
		periphAccess <= acc;
		@(posedge clk);
		periphAccess <= 32'h0;
		@(negedge clk);
	endtask
	task end_sim;
		$display("compares=%0d fails=%0d", compares, fails);
		if (fails == 0 && compares > 0)
			$display("ALL CHECKS OK");
		else
			$display("CHECKS NOT OK");
		$finish;
	endtask
	initial begin
		rst_b <= 1'b0;
		repeat (10) @(posedge clk);
		rst_b <= 1'b1;
		rdc(12'h114, 32'h0);
		wr(12'h114, 32'hFFFFFFFF);
		rdc(12'h114, 32'h07071013);
		rdc(12'h300, 32'h0);
		wr(12'h104, 32'h00001000);
		ps(2'h1);
		chk(periphClkEn, 32'h00001000);
		ps(2'h2);
		chk(periphClkEn, 32'h00001000);
		wr(12'h060, 32'h00400000);
		ps(2'h1);
		chk(periphClkEn, 32'h07071013);
		wr(12'h124, 32'h00000010);
		ps(2'h2);
		chk(periphClkEn, 32'h00000010);
		ps(2'h0);
		chk(periphClkEn, 32'h00001000);
		ps(2'h3);
		chk(periphClkEn, 32'h00001000);
		wr(12'h204, 32'h1);
		fault(32'h00001011);
		chk(faultTarget, 32'h00000011);
		chk(busFault, 32'h1);
		@(negedge clk) chk(irq, 32'h1);
		wr(12'h200, 32'h1);
		@(posedge clk);
		repeat (2) @(negedge clk) chk(irq, 32'h0);
		wr(12'h204, 32'h0);
		fault(32'h00000002);
		chk(faultTarget, 32'h00000002);
		@(negedge clk) chk(irq, 32'h0);
		@(posedge clk) rst_b <= 1'b0;
		repeat (2) @(posedge clk);
		rst_b <= 1'b1;
		rdc(12'h104, 32'h0);
		chk(periphClkEn, 32'h0);
		end_sim;
	end
endmodule // tb_top
